// File: design/acd_pkg.sv
package acd_pkg;
  // Register map (word index = address)
  localparam logic [3:0]  MODE_ADDR   = 4'h2;
  localparam logic [3:0]  CLOCK_ADDR  = 4'h3;
  localparam logic [3:0]  STAT_ADDR   = 4'h1;
  localparam logic [15:0] CLOCK_RESET = 16'h030e;
  localparam logic [3:0]  MODE_RESET  = 4'h0;
  // Clock register fields
  localparam int CH1_BIT = 9;
  localparam int CH0_BIT = 8;
  localparam int FAST_BIT = 5;
  localparam int OSR_LSB = 2;
  localparam int PWR_LSB = 0;
  localparam int CLK_KEEP = 10;
  // Mode register fields
  localparam int SRC_LSB = 2;
  localparam int FLOAT_BIT = 1;
  localparam int FMT_BIT = 0;
  localparam int MODE_KEEP = 4;
  // Source codes
  localparam logic [1:0] SRC_LAG = 2'h0;
  localparam logic [1:0] SRC_OR  = 2'h1;
  // Ratios
  localparam logic [14:0] RATIO_FAST = 15'h0040;
  localparam logic [14:0] RATIO_TOP  = 15'h3f80;
  localparam logic [14:0] RATIO_BASE = 15'h0080;
  // Fixed low pulse on the pin
  localparam int PULSE_NS = 20;
  localparam int CLK_PS = 5000;
  localparam int PULSE_CYC = (PULSE_NS * 1000 + CLK_PS - 1) / CLK_PS;

  typedef enum logic [1:0] {PWR_VLOW, PWR_LOW, PWR_HIRES} acd_power_e;
  typedef enum logic [1:0] {PIN_IDLE, PIN_HOLD, PIN_PULSE} acd_pin_e;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } acd_bus_s;

  typedef struct packed {
    logic [CLK_KEEP-1:0]  clk_reg;
    logic [MODE_KEEP-1:0] mode_reg;
    logic [1:0]           flags;
    logic [1:0]           flags_prev;
    acd_pin_e             pin;
    logic [2:0]           cnt;
    logic [15:0]          rdata;
  } acd_state_s;
endpackage : acd_pkg

// File: design/acd_config.sv
// The implementer's own choice: strobed register access.
`timescale 1ns/1ps

// Behaviour
// - The pin follows the selected source: 00 most lagging, 01 OR of enabled channels, 10/11 most leading.
// - With no result pending the pin is driven high, or floated when the idle-float bit is set.
// - On new data the pin is held low, or pulsed low for a fixed time when the format bit is set.
// - Clock register bit 9 turns channel 1 on, reset on.
// - Clock register bit 8 turns channel 0 on, reset on.
// - Clock register bit 5 forces a ratio of 64 and overrides the ratio field.
// - Ratio field bits 4:2 decode to 128 through 8192 and 16256, reset code 011 for 1024.
// - Power field bits 1:0 decode to very low, low, and high resolution for 10 or 11, reset 10.
// - The clock register resets to 030e.
// - Each channel keeps a new-result flag set by a fresh result while the channel is on, feeding the pin.
module acd_config (
  input  wire logic              mclk,
  input  wire logic              rstn,
  input  wire acd_pkg::acd_bus_s bus,
  output logic [15:0]            rdata,
  input  wire logic              first_result_evt,
  input  wire logic              second_result_evt,
  input  wire logic              results_taken,
  output logic                   first_channel_on,
  output logic                   second_channel_on,
  output logic [14:0]            oversample_ratio,
  output acd_pkg::acd_power_e    power_level,
  output logic                   first_channel_new_result,
  output logic                   second_channel_new_result,
  output logic                   result_pending_pin_o,
  output logic                   result_pending_pin_oe
);

  acd_pkg::acd_state_s s_q;
  acd_pkg::acd_state_s s_d;

  // Level of the selected source for a given flag pair
  function automatic logic src_level(input logic [1:0] f, input logic [1:0] en,
                                     input logic [1:0] sel);
    logic [1:0] live;
    live = f & en;
    if (en == 2'h0)
      src_level = 1'b0;
    else if (sel == acd_pkg::SRC_LAG)
      src_level = ((f | ~en) == 2'h3);
    else
      src_level = |live;
  endfunction : src_level

  // Ratio field decode, top code is not a power of two
  function automatic logic [14:0] ratio(input logic fast, input logic [2:0] code);
    if (fast)
      ratio = acd_pkg::RATIO_FAST;
    else if (code == 3'h7)
      ratio = acd_pkg::RATIO_TOP;
    else
      ratio = acd_pkg::RATIO_BASE << code;
  endfunction : ratio

  logic [1:0] en;
  logic [1:0] sel;
  logic       fmt;
  logic       lvl;
  logic       lvl_prev;
  logic       trig;
  logic [1:0] ev;

  // Field views of the stored registers
  always_comb
  begin
    en   = {s_q.clk_reg[acd_pkg::CH1_BIT], s_q.clk_reg[acd_pkg::CH0_BIT]};
    sel  = s_q.mode_reg[acd_pkg::SRC_LSB +: 2];
    fmt  = s_q.mode_reg[acd_pkg::FMT_BIT];
    ev   = {second_result_evt, first_result_evt} & en;
    lvl  = src_level(s_q.flags, en, sel);
    lvl_prev = src_level(s_q.flags_prev, en, sel);
    // OR mode fires on every channel arrival, others on the source edge
    if (sel == acd_pkg::SRC_OR)
      trig = |(s_q.flags & ~s_q.flags_prev & en);
    else
      trig = lvl & ~lvl_prev;
  end

  // Next state
  always_comb
  begin
    s_d = s_q;
    s_d.rdata = 16'h0000;
    // Set beats the clear so no result is lost
    s_d.flags = (s_q.flags & ~{2{results_taken}}) | ev;
    s_d.flags_prev = s_q.flags;
    if (bus.wr && bus.addr == acd_pkg::CLOCK_ADDR)
      s_d.clk_reg = bus.wdata[acd_pkg::CLK_KEEP-1:0];
    if (bus.wr && bus.addr == acd_pkg::MODE_ADDR)
      s_d.mode_reg = bus.wdata[acd_pkg::MODE_KEEP-1:0];
    if (bus.rd)
    begin
      unique case (bus.addr)
        acd_pkg::CLOCK_ADDR: s_d.rdata = {6'h00, s_q.clk_reg};
        acd_pkg::MODE_ADDR:  s_d.rdata = {12'h000, s_q.mode_reg};
        acd_pkg::STAT_ADDR:  s_d.rdata = {14'h0000, s_q.flags};
        default:             s_d.rdata = 16'h0000;
      endcase
    end
    // Pin sequencer; a format change only applies at the next edge
    unique case (s_q.pin)
      acd_pkg::PIN_IDLE:
      begin
        if (trig && fmt)
        begin
          s_d.pin = acd_pkg::PIN_PULSE;
          s_d.cnt = 3'(acd_pkg::PULSE_CYC - 1);
        end
        else if (trig)
          s_d.pin = acd_pkg::PIN_HOLD;
      end
      acd_pkg::PIN_HOLD:
      begin
        if (!lvl)
          s_d.pin = acd_pkg::PIN_IDLE;
      end
      acd_pkg::PIN_PULSE:
      begin
        if (s_q.cnt == 3'h0)
          s_d.pin = acd_pkg::PIN_IDLE;
        else
          s_d.cnt = s_q.cnt - 3'h1;
      end
      default: s_d.pin = acd_pkg::PIN_IDLE;
    endcase
  end

  // State register
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      s_q.clk_reg    <= acd_pkg::CLOCK_RESET[acd_pkg::CLK_KEEP-1:0];
      s_q.mode_reg   <= acd_pkg::MODE_RESET;
      s_q.flags      <= 2'h0;
      s_q.flags_prev <= 2'h0;
      s_q.pin        <= acd_pkg::PIN_IDLE;
      s_q.cnt        <= 3'h0;
      s_q.rdata      <= 16'h0000;
    end
    else
      s_q <= s_d;
  end

  // Outputs
  always_comb
  begin
    rdata = s_q.rdata;
    first_channel_on  = s_q.clk_reg[acd_pkg::CH0_BIT];
    second_channel_on = s_q.clk_reg[acd_pkg::CH1_BIT];
    oversample_ratio = ratio(s_q.clk_reg[acd_pkg::FAST_BIT],
                             s_q.clk_reg[acd_pkg::OSR_LSB +: 3]);
    // Codes 10 and 11 both mean high resolution
    unique case (s_q.clk_reg[acd_pkg::PWR_LSB +: 2])
      2'h0:    power_level = acd_pkg::PWR_VLOW;
      2'h1:    power_level = acd_pkg::PWR_LOW;
      default: power_level = acd_pkg::PWR_HIRES;
    endcase
    first_channel_new_result  = s_q.flags[0];
    second_channel_new_result = s_q.flags[1];
    // Low while active, else high or released
    result_pending_pin_o  = (s_q.pin == acd_pkg::PIN_IDLE);
    result_pending_pin_oe = (s_q.pin != acd_pkg::PIN_IDLE)
                          || !s_q.mode_reg[acd_pkg::FLOAT_BIT];
  end

  a_lag_waits_all: assert property (@(posedge mclk) disable iff (!rstn)
    (sel == acd_pkg::SRC_LAG && en == 2'h3 && s_q.flags != 2'h3)
      |-> !lvl)
    else $error("lagging source fired before both channels");

  a_idle_level: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.pin == acd_pkg::PIN_IDLE)
      |-> (result_pending_pin_o && result_pending_pin_oe == !s_q.mode_reg[acd_pkg::FLOAT_BIT]))
    else $error("idle pin level or float wrong");

  a_hold_low: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.pin == acd_pkg::PIN_IDLE && trig && !fmt)
      |=> (!result_pending_pin_o && result_pending_pin_oe) until !lvl)
    else $error("held low format did not stay low");

  a_pulse_width: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.pin == acd_pkg::PIN_IDLE && trig && fmt)
      |=> !result_pending_pin_o [*4] ##1 result_pending_pin_o)
    else $error("pulse width wrong");

  a_ch1_enable: assert property (@(posedge mclk) disable iff (!rstn)
    (bus.wr && bus.addr == acd_pkg::CLOCK_ADDR)
      |=> second_channel_on == $past(bus.wdata[acd_pkg::CH1_BIT]))
    else $error("channel 1 enable not written");

  a_ch0_enable: assert property (@(posedge mclk) disable iff (!rstn)
    (bus.wr && bus.addr == acd_pkg::CLOCK_ADDR)
      |=> first_channel_on == $past(bus.wdata[acd_pkg::CH0_BIT]))
    else $error("channel 0 enable not written");

  a_fast_ratio: assert property (@(posedge mclk) disable iff (!rstn)
    s_q.clk_reg[acd_pkg::FAST_BIT] |-> oversample_ratio == 15'h0040)
    else $error("override ratio not 64");

  a_ratio_decode: assert property (@(posedge mclk) disable iff (!rstn)
    (!s_q.clk_reg[acd_pkg::FAST_BIT] && s_q.clk_reg[4:2] == 3'h3)
      |-> oversample_ratio == 15'h0400)
    else $error("ratio code 3 not 1024");

  a_power_decode: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.clk_reg[1]) |-> power_level == acd_pkg::PWR_HIRES)
    else $error("power code 1x not high resolution");

  a_reset_value: assert property (@(posedge mclk)
    $rose(rstn) |-> ({6'h00, s_q.clk_reg} == 16'h030e))
    else $error("clock register reset value wrong");

  a_flag_set: assert property (@(posedge mclk) disable iff (!rstn)
    (first_result_evt && first_channel_on) |=> first_channel_new_result)
    else $error("new result flag lost");

  a_reserved_zero: assert property (@(posedge mclk) disable iff (!rstn)
    (bus.rd && bus.addr == acd_pkg::CLOCK_ADDR) |=> rdata[15:10] == 6'h00)
    else $error("reserved bits not zero");

  a_or_each_arrival: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.pin == acd_pkg::PIN_IDLE && sel == acd_pkg::SRC_OR && |(s_q.flags & ~s_q.flags_prev & en))
      |=> (s_q.pin != acd_pkg::PIN_IDLE))
    else $error("or source missed an arrival");

  a_lead_first: assert property (@(posedge mclk) disable iff (!rstn)
    (sel[1] && |(s_q.flags & en))
      |-> lvl)
    else $error("leading source ignored first channel");

  a_no_enabled: assert property (@(posedge mclk) disable iff (!rstn)
    (en == 2'h0)
      |-> !lvl)
    else $error("source high with no channel enabled");

  a_active_driven: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.pin != acd_pkg::PIN_IDLE)
      |-> (!result_pending_pin_o && result_pending_pin_oe))
    else $error("active pin not driven low");

  a_float_idle: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.pin == acd_pkg::PIN_IDLE && s_q.mode_reg[acd_pkg::FLOAT_BIT])
      |-> !result_pending_pin_oe)
    else $error("idle pin driven while float set");

  a_pulse_ends: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.pin == acd_pkg::PIN_PULSE && s_q.cnt == 3'h0)
      |=> (s_q.pin == acd_pkg::PIN_IDLE))
    else $error("pulse did not end");

  a_hold_release: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.pin == acd_pkg::PIN_HOLD && !lvl)
      |=> result_pending_pin_o)
    else $error("held pin not released");

  a_ch1_gates_flag: assert property (@(posedge mclk) disable iff (!rstn)
    (second_result_evt && !second_channel_on && !s_q.flags[1])
      |=> !second_channel_new_result)
    else $error("disabled channel 1 raised a flag");

  a_ch0_gates_flag: assert property (@(posedge mclk) disable iff (!rstn)
    (first_result_evt && !first_channel_on && !s_q.flags[0])
      |=> !first_channel_new_result)
    else $error("disabled channel 0 raised a flag");

  a_fast_write: assert property (@(posedge mclk) disable iff (!rstn)
    (bus.wr && bus.addr == acd_pkg::CLOCK_ADDR && bus.wdata[acd_pkg::FAST_BIT])
      |=> oversample_ratio == acd_pkg::RATIO_FAST)
    else $error("override write did not give 64");

  a_ratio_top: assert property (@(posedge mclk) disable iff (!rstn)
    (!s_q.clk_reg[acd_pkg::FAST_BIT] && s_q.clk_reg[acd_pkg::OSR_LSB +: 3] == 3'h7)
      |-> oversample_ratio == acd_pkg::RATIO_TOP)
    else $error("top ratio code wrong");

  a_power_vlow: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.clk_reg[acd_pkg::PWR_LSB +: 2] == 2'h0)
      |-> power_level == acd_pkg::PWR_VLOW)
    else $error("power code 0 not very low");

  a_power_low: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.clk_reg[acd_pkg::PWR_LSB +: 2] == 2'h1)
      |-> power_level == acd_pkg::PWR_LOW)
    else $error("power code 1 not low");

  a_flag_hold: assert property (@(posedge mclk) disable iff (!rstn)
    (s_q.flags[0] && !results_taken)
      |=> first_channel_new_result)
    else $error("new result flag dropped early");

  a_flag_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (results_taken && !(first_result_evt && first_channel_on))
      |=> !first_channel_new_result)
    else $error("new result flag not cleared");

  a_set_beats_clear: assert property (@(posedge mclk) disable iff (!rstn)
    (results_taken && second_result_evt && second_channel_on)
      |=> second_channel_new_result)
    else $error("clear beat a fresh result");

endmodule : acd_config

// File: test/acd_host_model.sv
`timescale 1ns/1ps

module acd_host_model (
  input  wire logic mclk,
  input  wire logic rstn,
  input  wire logic pin_o,
  input  wire logic pin_oe,
  input  wire logic take_req,
  output logic       pin_lvl,
  output logic       results_taken,
  output logic [7:0] low_cnt
);
  logic last_q;

  // No pull-up on the line, so a floated pin reads as the inverse of its last level
  assign pin_lvl = pin_oe ? pin_o : ~last_q;

  // Host counts low cycles on the wire and acks results a cycle after a request
  always_ff @(posedge mclk or negedge rstn)
  begin
    if (!rstn)
    begin
      last_q        <= 1'b1;
      low_cnt       <= 8'h00;
      results_taken <= 1'b0;
    end
    else
    begin
      last_q        <= pin_oe ? pin_o : last_q;
      low_cnt       <= low_cnt + 8'(pin_oe && !pin_o);
      results_taken <= take_req;
    end
  end
endmodule : acd_host_model

// File: test/adc_clock_result_pending_pin_config_tb.sv
`timescale 1ns/1ps

module adc_clock_result_pending_pin_config_tb;
  logic                mclk, rstn, fe, se, take_req, rtk, pin_lvl;
  logic                f_on, s_on, f_new, s_new, pin_o, pin_oe;
  logic [15:0]         rdata;
  logic [14:0]         ratio;
  logic [7:0]          low_cnt, base;
  acd_pkg::acd_power_e power_level_sel;
  acd_pkg::acd_bus_s   bus;
  int                  miscompares, n_compared, cyc;

  acd_config uut (
    .mclk(mclk), .rstn(rstn), .bus(bus), .rdata(rdata),
    .first_result_evt(fe), .second_result_evt(se), .results_taken(rtk),
    .first_channel_on(f_on), .second_channel_on(s_on),
    .oversample_ratio(ratio), .power_level(power_level_sel),
    .first_channel_new_result(f_new), .second_channel_new_result(s_new),
    .result_pending_pin_o(pin_o), .result_pending_pin_oe(pin_oe)
  );

  acd_host_model host (
    .mclk(mclk), .rstn(rstn), .pin_o(pin_o), .pin_oe(pin_oe),
    .take_req(take_req), .pin_lvl(pin_lvl), .results_taken(rtk), .low_cnt(low_cnt)
  );

  // Clock and hang guard
  initial
  begin
    mclk = 1'b0;
    forever #2.5 mclk = ~mclk;
  end

  always @(posedge mclk)
  begin
    cyc = cyc + 1;
    if (cyc == 2000)
    begin
      miscompares++;
      summarize;
    end
  end

  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp)
    begin
      miscompares++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask : chk

  // Bus cycles: one-cycle strobes, read data sampled in the following cycle
  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    bus <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge mclk);
    bus.wr <= 1'b0;
    @(negedge mclk);
  endtask : wr

  task automatic rchk(input logic [3:0] a, input logic [15:0] exp);
    @(posedge mclk);
    bus <= '{addr: a, wdata: 16'h0000, wr: 1'b0, rd: 1'b1};
    @(posedge mclk);
    bus.rd <= 1'b0;
    @(negedge mclk);
    chk(rdata, exp);
  endtask : rchk

  // One-cycle result pulses; pin settles two cycles later
  task automatic ev(input logic f, input logic s);
    @(posedge mclk);
    fe <= f;
    se <= s;
    @(posedge mclk);
    fe <= 1'b0;
    se <= 1'b0;
    repeat (2) @(posedge mclk);
    @(negedge mclk);
  endtask : ev

  task automatic take;
    @(posedge mclk);
    take_req <= 1'b1;
    @(posedge mclk);
    take_req <= 1'b0;
    repeat (3) @(posedge mclk);
    @(negedge mclk);
  endtask : take

  task automatic summarize;
    $display("compared %0d miscompares %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : summarize

  // Main sequence
  initial
  begin
    cyc = 0;
    fe = 1'b0;
    se = 1'b0;
    take_req = 1'b0;
    bus = '0;
    rstn = 1'b0;
    repeat (8) @(posedge mclk);
    rstn <= 1'b1;
    rchk(acd_pkg::CLOCK_ADDR, 16'h030e);
    chk(16'({s_on, f_on}), 16'h0003);
    chk(16'(ratio), 16'h0400);
    chk(16'(power_level_sel), 16'h0002);
    chk(16'({pin_o, pin_oe}), 16'h0003);
    wr(acd_pkg::CLOCK_ADDR, 16'hfc3f);
    rchk(acd_pkg::CLOCK_ADDR, 16'h003f);
    chk(16'({s_on, f_on}), 16'h0000);
    chk(16'(ratio), 16'h0040);
    for (int i = 0; i < 8; i++)
    begin
      wr(acd_pkg::CLOCK_ADDR, 16'h0300 | 16'(i << 2) | 16'(i[1:0]));
      chk(16'(ratio), (i == 7) ? 16'h3f80 : 16'h0080 << i);
      chk(16'(power_level_sel), (i[1:0] == 2'h3) ? 16'h0002 : 16'(i[1:0]));
    end
    // Lagging source waits for both channels
    wr(acd_pkg::MODE_ADDR, 16'h0000);
    ev(1'b1, 1'b0);
    chk(16'({f_new, pin_lvl}), 16'h0003);
    ev(1'b0, 1'b1);
    chk(16'({s_new, pin_lvl}), 16'h0002);
    take;
    chk(16'({s_new, f_new, pin_lvl}), 16'h0001);
    for (int s = 1; s < 4; s++)
    begin
      wr(acd_pkg::MODE_ADDR, 16'(s << 2));
      ev(1'b0, 1'b1);
      chk(16'(pin_lvl), 16'h0000);
      take;
    end
    // Disabled channel raises no flag
    wr(acd_pkg::CLOCK_ADDR, 16'h020e);
    ev(1'b1, 1'b0);
    chk(16'({f_new, pin_lvl}), 16'h0001);
    wr(acd_pkg::CLOCK_ADDR, 16'h030e);
    wr(acd_pkg::MODE_ADDR, 16'h0002);
    chk(16'(pin_oe), 16'h0000);
    wr(acd_pkg::MODE_ADDR, 16'h0001);
    base = low_cnt;
    ev(1'b1, 1'b1);
    repeat (12) @(posedge mclk);
    @(negedge mclk);
    chk(16'(low_cnt - base), 16'h0004);
    chk(16'(pin_lvl), 16'h0001);
    rchk(acd_pkg::STAT_ADDR, 16'h0003);
    rchk(4'h5, 16'h0000);
    summarize;
  end
endmodule : adc_clock_result_pending_pin_config_tb
